// File: config_feature_select.sv
// Configuration, pin multiplexing and compatibility control of the audio system
`timescale 1ns/1ps
`default_nettype none
`include "config_defines.svh"

module config_feature_select #(
	parameter logic [7:0]         IDENT_VALUE  = 8'h5a,  // Arbitrary value
	parameter logic [7:0]         COMPAT_VALUE = 8'ha3   // Arbitrary value
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// Control block port access
	input  wire logic             i_ctrl_wr,
	input  wire logic             i_ctrl_rd,
	input  wire logic [2:0]       i_ctrl_off,
	input  wire logic [7:0]       i_ctrl_wdata,
	output logic      [7:0]       o_ctrl_rdata,
	// Codec indirect register access
	input  wire logic             i_codec_wr,
	input  wire logic             i_codec_rd,
	input  wire logic             i_codec_ext,
	input  wire logic [4:0]       i_codec_idx,
	input  wire logic [7:0]       i_codec_wdata,
	input  wire logic             i_remap_en,
	output logic      [7:0]       o_codec_rdata,
	// Peripheral port and joystick
	input  wire logic             i_periph_rd,
	input  wire logic             i_game_sel,
	input  wire logic [2:0]       i_game_off,
	output logic                  o_isa_read_drive,
	output logic                  o_game_decode,
	// Serial port
	input  wire logic             i_serial_enable,
	output logic                  o_serial_run,
	output logic      [1:0]       o_serial_format,
	// Pin multiplexing and modes
	output logic                  o_wavetable_pins,
	output logic                  o_dsp_on_periph_pins,
	output logic      [1:0]       o_volume_format,
	output logic      [1:0]       o_codec_mode,
	output logic                  o_legacy_mode_two_bit,
	output logic                  o_output_level_bit,
	// Synthesis volume and line volume
	input  wire logic             i_synth_vol_wr,
	input  wire logic [7:0]       i_synth_vol_left,
	input  wire logic [7:0]       i_synth_vol_right,
	output logic      [7:0]       o_line_vol_left,
	output logic      [7:0]       o_line_vol_right,
	// Hardware configuration stream
	input  wire logic             i_cfg_start,
	input  wire logic             i_cfg_byte_valid,
	input  wire logic [3:0]       i_cfg_byte_index,
	input  wire logic [7:0]       i_cfg_byte,
	input  wire logic             i_cfg_end,
	output logic                  o_cfg_busy,
	output logic                  o_fw_load,
	output logic                  o_fw_skip
);

	////////////////////////////////////////////////////////////////////////////
	// Indirect control registers

	ctrl_regs_if ctrl_bus ();

	assign ctrl_bus.wr    = i_ctrl_wr;
	assign ctrl_bus.off   = i_ctrl_off;
	assign ctrl_bus.wdata = i_ctrl_wdata;

	ctrl_indirect_regs #(
		.NUM_REGS    (`CTRL_NUM_REGS),
		.IDENT_VALUE (IDENT_VALUE)
	) u_ctrl_regs (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.bus   (ctrl_bus)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ctrl_rdata <= `RST_BYTE;
		end else if (i_ctrl_rd) begin
			o_ctrl_rdata <= ctrl_bus.rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Hardware configuration capture and code base check

	config_pkg::cfg_state_type state_q;
	config_pkg::cfg_state_type state_d;
	config_pkg::byte_type      global_q;
	config_pkg::byte_type      code_base_q;

	wire cfg_take    = (state_q == config_pkg::CFG_READ) && i_cfg_byte_valid;
	wire take_global = cfg_take && (i_cfg_byte_index == `HWCFG_IDX_GLOBAL);
	wire take_code   = cfg_take && (i_cfg_byte_index == `HWCFG_IDX_CODE_BASE);
	// The last byte may arrive with the end strobe, so look at it directly
	wire [7:0] code_now   = take_code ? i_cfg_byte : code_base_q;
	wire       fw_allowed = (code_now == `CODE_BASE_FIRMWARE);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			config_pkg::CFG_IDLE:    if (i_cfg_start) state_d = config_pkg::CFG_READ;
			config_pkg::CFG_READ:    if (i_cfg_end) state_d = fw_allowed ?
			                             config_pkg::CFG_FW_LOAD : config_pkg::CFG_FW_SKIP;
			config_pkg::CFG_FW_LOAD: if (i_cfg_start) state_d = config_pkg::CFG_READ;
			config_pkg::CFG_FW_SKIP: if (i_cfg_start) state_d = config_pkg::CFG_READ;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q     <= config_pkg::CFG_IDLE;
			global_q    <= `RST_BYTE;
			code_base_q <= `CODE_BASE_LEGACY;
		end else begin
			state_q <= state_d;
			if (take_global) global_q <= i_cfg_byte;
			if (take_code) code_base_q <= i_cfg_byte;
		end
	end

	// Configuration data is read whatever the code base says; only firmware is gated
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cfg_busy <= 1'b0;
			o_fw_load  <= 1'b0;
			o_fw_skip  <= 1'b0;
		end else begin
			o_cfg_busy <= (state_d == config_pkg::CFG_READ);
			o_fw_load  <= (state_d == config_pkg::CFG_FW_LOAD);
			o_fw_skip  <= (state_d == config_pkg::CFG_FW_SKIP);
		end
	end

	wire ifm_on  = global_q[`GCB_IFM_BIT];
	wire sdd_on  = global_q[`GCB_SDD_BIT];
	wire synth_line_decouple_on = global_q[`GCB_SYNTH_LINE_DECOUPLE_BIT];
	wire wavetable_port_enable_on = global_q[`GCB_WAVETABLE_PORT_ENABLE_BIT] | ctrl_bus.pin_cfg[`PIN_CFG_WAVETABLE_PORT_ENABLE_BIT];
	wire sps_on  = global_q[`GCB_SPS_BIT]  | ctrl_bus.pin_cfg[`PIN_CFG_SPS_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Codec indirect registers

	config_pkg::byte_type mode_q;
	config_pkg::byte_type alt_q;
	config_pkg::byte_type line_l_q;
	config_pkg::byte_type line_r_q;

	function automatic config_pkg::byte_type line_view(input config_pkg::byte_type val,
	                                                   input logic keep);
		line_view = (val[`LINE_MUTE_BIT] && !keep) ? `LINE_MUTED_PATTERN : val;
	endfunction : line_view

	wire codec_std_wr = i_codec_wr && !i_codec_ext;
	wire keep_line    = ifm_on && i_remap_en;
	wire wr_mode      = codec_std_wr && (i_codec_idx == `CODEC_IDX_MODE);
	wire wr_alt       = codec_std_wr && (i_codec_idx == `CODEC_IDX_ALT_FEAT);
	wire wr_line_l    = codec_std_wr && (i_codec_idx == `CODEC_IDX_LINE_L);
	wire wr_line_r    = codec_std_wr && (i_codec_idx == `CODEC_IDX_LINE_R);
	wire synth_line   = i_synth_vol_wr && !synth_line_decouple_on;

	// Output level bit always reads as set; a write cannot clear it
	wire config_pkg::byte_type alt_view = alt_q | (8'h01 << `ALT_OLB_BIT);

	wire config_pkg::byte_type std_rd =
		(i_codec_idx == `CODEC_IDX_MODE)     ? mode_q :
		(i_codec_idx == `CODEC_IDX_ALT_FEAT) ? alt_view :
		(i_codec_idx == `CODEC_IDX_LINE_L)   ? line_view(line_l_q, keep_line) :
		(i_codec_idx == `CODEC_IDX_LINE_R)   ? line_view(line_r_q, keep_line) :
		(i_codec_idx == `CODEC_IDX_COMPAT)   ? COMPAT_VALUE : `RST_BYTE;
	wire config_pkg::byte_type ext_rd =
		(i_codec_idx == `EXT_IDX_IDENT) ? IDENT_VALUE : `RST_BYTE;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_q   <= `RST_BYTE;
			alt_q    <= `RST_BYTE;
			line_l_q <= `RST_LINE;
			line_r_q <= `RST_LINE;
		end else begin
			if (wr_mode) mode_q <= i_codec_wdata;
			if (wr_alt) alt_q <= i_codec_wdata & ~(8'h01 << `ALT_OLB_BIT);
			// Host writes take precedence over a coincident synthesis write
			if (wr_line_l) line_l_q <= i_codec_wdata;
			else if (synth_line) line_l_q <= i_synth_vol_left;
			if (wr_line_r) line_r_q <= i_codec_wdata;
			else if (synth_line) line_r_q <= i_synth_vol_right;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_codec_rdata <= `RST_BYTE;
		end else if (i_codec_rd) begin
			o_codec_rdata <= i_codec_ext ? ext_rd : std_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus drive, decode, serial port and pin multiplexing

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_isa_read_drive      <= 1'b0;
			o_game_decode         <= 1'b0;
			o_serial_run          <= 1'b0;
			o_serial_format       <= 2'h0;
			o_wavetable_pins      <= 1'b0;
			o_dsp_on_periph_pins  <= 1'b0;
			o_volume_format       <= 2'h0;
			o_codec_mode          <= 2'h0;
			o_legacy_mode_two_bit <= 1'b0;
			o_output_level_bit    <= 1'b1;
			o_line_vol_left       <= `RST_LINE;
			o_line_vol_right      <= `RST_LINE;
		end else begin
			o_isa_read_drive      <= i_periph_rd && !sdd_on;
			o_game_decode         <= i_game_sel && (i_game_off <= `GAME_LAST_OFFSET);
			// Capture and playback enables are deliberately not part of this term
			o_serial_run          <= i_serial_enable;
			o_serial_format       <= alt_q[`ALT_SF_HI_BIT:`ALT_SF_LO_BIT];
			o_wavetable_pins      <= wavetable_port_enable_on;
			o_dsp_on_periph_pins  <= sps_on;
			o_volume_format       <= {global_q[`GCB_VCF_HI_BIT], global_q[`GCB_VCF_LO_BIT]};
			o_codec_mode          <= mode_q[`MODE_CMS_HI_BIT:`MODE_CMS_LO_BIT];
			o_legacy_mode_two_bit <= mode_q[`MODE_CMS_HI_BIT];
			o_output_level_bit    <= 1'b1;
			o_line_vol_left       <= line_l_q;
			o_line_vol_right      <= line_r_q;
		end
	end

endmodule : config_feature_select

`default_nettype wire

// File: config_defines.svh
// Offsets, field positions, reset values and codes of the configuration block
`ifndef CONFIG_DEFINES_SVH
`define CONFIG_DEFINES_SVH

// Control block offsets and indirect space
`define CTRL_OFF_INDEX      3'h3
`define CTRL_OFF_DATA       3'h4
`define CTRL_IDX_IDENT      4'h1
`define CTRL_IDX_PIN_CFG    4'h8
`define CTRL_NUM_REGS       9

// Pin configuration register fields
`define PIN_CFG_WAVETABLE_PORT_ENABLE_BIT    7
`define PIN_CFG_SPS_BIT     6

// Global configuration byte fields
`define GCB_IFM_BIT         7
`define GCB_SDD_BIT         6
`define GCB_WAVETABLE_PORT_ENABLE_BIT        5
`define GCB_SPS_BIT         4
`define GCB_SYNTH_LINE_DECOUPLE_BIT        3
`define GCB_VCF_HI_BIT      1
`define GCB_VCF_LO_BIT      0

// Hardware configuration byte positions and code base values
`define HWCFG_IDX_GLOBAL    4'h3
`define HWCFG_IDX_CODE_BASE 4'h9
`define CODE_BASE_FIRMWARE  8'h0b
`define CODE_BASE_LEGACY    8'h43

// Codec indirect register numbers
`define CODEC_IDX_MODE      5'h0c
`define CODEC_IDX_ALT_FEAT  5'h10
`define CODEC_IDX_LINE_L    5'h12
`define CODEC_IDX_LINE_R    5'h13
`define CODEC_IDX_COMPAT    5'h19
`define CODEC_IDX_RSVD_A    5'h1b
`define CODEC_IDX_RSVD_B    5'h1d
`define EXT_IDX_IDENT       5'h19

// Codec register fields
`define MODE_CMS_HI_BIT     6
`define MODE_CMS_LO_BIT     5
`define ALT_OLB_BIT         7
`define ALT_SF_HI_BIT       5
`define ALT_SF_LO_BIT       4
`define LINE_MUTE_BIT       7
`define LINE_MUTED_PATTERN  8'hbf

// Joystick decode
`define GAME_LAST_OFFSET    3'h5

// Reset values
`define RST_BYTE            8'h00
`define RST_LINE            8'h00

`endif

// File: config_pkg.sv
// Types shared by the configuration and compatibility control block
package config_pkg;

	typedef enum logic [1:0] {
		CFG_IDLE,
		CFG_READ,
		CFG_FW_LOAD,
		CFG_FW_SKIP
	} cfg_state_type;

	typedef logic [7:0] byte_type;

endpackage : config_pkg

// File: ctrl_regs_if.sv
// Carrier between the top block and its indirect control register file
`timescale 1ns/1ps
`default_nettype none

interface ctrl_regs_if;
	logic                wr;
	logic [2:0]          off;
	config_pkg::byte_type wdata;
	config_pkg::byte_type rdata;
	config_pkg::byte_type pin_cfg;

	modport host (output wr, output off, output wdata, input rdata, input pin_cfg);
	modport regs (input wr, input off, input wdata, output rdata, output pin_cfg);
endinterface : ctrl_regs_if

`default_nettype wire

// File: ctrl_indirect_regs.sv
// Indirect control register file behind the index and data ports
`timescale 1ns/1ps
`default_nettype none
`include "config_defines.svh"

module ctrl_indirect_regs #(
	parameter int            NUM_REGS    = `CTRL_NUM_REGS,
	parameter logic [7:0]    IDENT_VALUE = 8'h5a  // Arbitrary value
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Register access
	ctrl_regs_if.regs        bus
);

	generate
		if (NUM_REGS < 9 || NUM_REGS > 16) begin : g_bad_size
			$error("NUM_REGS must lie between 9 and 16");
		end
	endgenerate

	logic [3:0]              index_q;
	config_pkg::byte_type    regs_q [NUM_REGS];

	wire                     idx_valid = (32'(index_q) < NUM_REGS);
	wire                     wr_index  = bus.wr && (bus.off == `CTRL_OFF_INDEX);
	wire                     wr_data   = bus.wr && (bus.off == `CTRL_OFF_DATA);
	wire config_pkg::byte_type data_rd =
		(index_q == `CTRL_IDX_IDENT) ? IDENT_VALUE :
		idx_valid                    ? regs_q[index_q] : `RST_BYTE;

	// Only the index and data ports are mapped
	assign bus.rdata   = (bus.off == `CTRL_OFF_INDEX) ? {4'h0, index_q} :
	                     (bus.off == `CTRL_OFF_DATA)  ? data_rd : `RST_BYTE;
	assign bus.pin_cfg = regs_q[`CTRL_IDX_PIN_CFG];

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			index_q <= 4'h0;
		end else if (wr_index) begin
			index_q <= bus.wdata[3:0];
		end
	end

	// Identity register is read only
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < NUM_REGS; i++) begin
			if (i_rst) begin
				regs_q[i] <= `RST_BYTE;
			end else if (wr_data && idx_valid && index_q == 4'(i)
			             && index_q != `CTRL_IDX_IDENT) begin
				regs_q[i] <= bus.wdata;
			end
		end
	end

endmodule : ctrl_indirect_regs

`default_nettype wire

// File: config_feature_select_properties.sv
// Port-level assertions for the configuration control block
`timescale 1ns/1ps
`default_nettype none

module config_feature_select_checker #(
	parameter logic [7:0] IDENT_VALUE  = 8'h5a,  // Arbitrary value
	parameter logic [7:0] COMPAT_VALUE = 8'ha3   // Arbitrary value
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Register ports
	input  wire logic       i_ctrl_rd,
	input  wire logic [2:0] i_ctrl_off,
	input  wire logic [7:0] o_ctrl_rdata,
	input  wire logic       i_codec_rd,
	input  wire logic       i_codec_ext,
	input  wire logic [4:0] i_codec_idx,
	input  wire logic [7:0] o_codec_rdata,
	// Pins and modes
	input  wire logic       i_periph_rd,
	input  wire logic       o_isa_read_drive,
	input  wire logic       i_game_sel,
	input  wire logic [2:0] i_game_off,
	input  wire logic       o_game_decode,
	input  wire logic       i_serial_enable,
	input  wire logic       o_serial_run,
	input  wire logic [1:0] o_codec_mode,
	input  wire logic       o_legacy_mode_two_bit,
	input  wire logic       o_output_level_bit,
	// Configuration stream
	input  wire logic       i_cfg_end,
	input  wire logic       o_cfg_busy,
	input  wire logic       o_fw_load,
	input  wire logic       o_fw_skip
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_unmapped_reads_zero: assert property (i_ctrl_rd && i_ctrl_off != 3'h3 &&
		i_ctrl_off != 3'h4 |=> o_ctrl_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_holds_idle: assert property (!i_ctrl_rd |=> $stable(o_ctrl_rdata))
		else $error("control read data moved without a read");
	a_read_drive_gated: assert property (o_isa_read_drive |-> $past(i_periph_rd))
		else $error("data bus driven without a peripheral read");
	a_serial_run_follows: assert property (1'b1 |=> o_serial_run == $past(i_serial_enable))
		else $error("serial port run does not follow its enable");
	a_game_offset_hit: assert property (i_game_sel && i_game_off <= 3'h5 |=> o_game_decode)
		else $error("joystick offset not decoded");
	a_game_reserved_off: assert property (i_game_sel && i_game_off > 3'h5 |=> !o_game_decode)
		else $error("reserved joystick offset decoded");
	a_compat_read_value: assert property (i_codec_rd && !i_codec_ext && i_codec_idx == 5'h19
		|=> o_codec_rdata == COMPAT_VALUE) else $error("compat register value wrong");
	a_ext_ident_value: assert property (i_codec_rd && i_codec_ext && i_codec_idx == 5'h19
		|=> o_codec_rdata == IDENT_VALUE) else $error("extended ident value wrong");
	a_reserved_codec_zero: assert property (i_codec_rd && !i_codec_ext &&
		(i_codec_idx == 5'h1b || i_codec_idx == 5'h1d) |=> o_codec_rdata == 8'h00)
		else $error("reserved codec register not zero");
	a_level_bit_set: assert property (o_output_level_bit)
		else $error("output level bit clear");
	a_mode_two_alias: assert property (o_legacy_mode_two_bit == o_codec_mode[1])
		else $error("mode-two bit differs from upper mode select");
	a_stream_end_result: assert property (i_cfg_end && o_cfg_busy |=> !o_cfg_busy &&
		(o_fw_load != o_fw_skip)) else $error("stream end gave no single result");

	c_fw_load: cover property (o_fw_load);
	c_fw_skip: cover property (o_fw_skip);
	c_game_hit: cover property (o_game_decode);
endmodule : config_feature_select_checker

bind config_feature_select config_feature_select_checker #(
	.IDENT_VALUE(IDENT_VALUE),
	.COMPAT_VALUE(COMPAT_VALUE)
) chk_i (.i_clk, .i_rst, .i_ctrl_rd, .i_ctrl_off, .o_ctrl_rdata, .i_codec_rd, .i_codec_ext,
	.i_codec_idx, .o_codec_rdata, .i_periph_rd, .o_isa_read_drive, .i_game_sel, .i_game_off,
	.o_game_decode, .i_serial_enable, .o_serial_run, .o_codec_mode, .o_legacy_mode_two_bit,
	.o_output_level_bit, .i_cfg_end, .o_cfg_busy, .o_fw_load, .o_fw_skip);

`default_nettype wire

// File: cfg_stream_model.sv
// Behavioural configuration memory streaming hardware configuration bytes
`timescale 1ns/1ps
`default_nettype none

module cfg_stream_model (
	// Clock
	input  wire logic       i_clk,
	// Stream toward the block
	output logic            o_start,
	output logic            o_valid,
	output logic      [3:0] o_index,
	output logic      [7:0] o_byte,
	output logic            o_end
);
	initial begin
		{o_start, o_valid, o_index, o_byte, o_end} = '0;
	end

	// Gap cycles toggle the data lines so no stale byte can be mistaken for data
	task automatic send(input logic [7:0] glob, input logic [7:0] code, input int gap);
		@(posedge i_clk) o_start <= 1'b1;
		@(posedge i_clk) o_start <= 1'b0;
		o_valid <= 1'b1;
		o_index <= 4'h3;
		o_byte  <= glob;
		repeat (gap) begin
			@(posedge i_clk) o_valid <= 1'b0;
			o_byte <= ~o_byte;
		end
		@(posedge i_clk) o_valid <= 1'b1;
		o_index <= 4'h9;
		o_byte  <= code;
		o_end   <= 1'b1;
		@(posedge i_clk) o_valid <= 1'b0;
		o_end  <= 1'b0;
		o_byte <= ~code;
	endtask : send
endmodule : cfg_stream_model

`default_nettype wire

// File: test_config_feature_select.sv
// Self-checking bench for the configuration control block
`timescale 1ns/1ps
`default_nettype none

module test_config_feature_select;
	logic       i_clk, i_rst, i_ctrl_wr, i_ctrl_rd, i_codec_wr, i_codec_rd, i_codec_ext;
	logic       i_remap_en, i_periph_rd, i_game_sel, i_serial_enable, i_synth_vol_wr;
	logic       i_cfg_start, i_cfg_byte_valid, i_cfg_end;
	logic [2:0] i_ctrl_off, i_game_off;
	logic [3:0] i_cfg_byte_index;
	logic [4:0] i_codec_idx;
	logic [7:0] i_ctrl_wdata, i_codec_wdata, i_synth_vol_left, i_synth_vol_right, i_cfg_byte;
	logic [7:0] o_ctrl_rdata, o_codec_rdata, o_line_vol_left, o_line_vol_right;
	logic       o_isa_read_drive, o_game_decode, o_serial_run, o_wavetable_pins;
	logic       o_dsp_on_periph_pins, o_legacy_mode_two_bit, o_output_level_bit;
	logic       o_cfg_busy, o_fw_load, o_fw_skip;
	logic [1:0] o_serial_format, o_volume_format, o_codec_mode;
	logic [7:0] q;
	int         error_cnt;
	int         n_tests;

	config_feature_select config_feature_select_i (.i_clk, .i_rst, .i_ctrl_wr, .i_ctrl_rd,
		.i_ctrl_off, .i_ctrl_wdata, .o_ctrl_rdata, .i_codec_wr, .i_codec_rd, .i_codec_ext,
		.i_codec_idx, .i_codec_wdata, .i_remap_en, .o_codec_rdata, .i_periph_rd, .i_game_sel,
		.i_game_off, .o_isa_read_drive, .o_game_decode, .i_serial_enable, .o_serial_run,
		.o_serial_format, .o_wavetable_pins, .o_dsp_on_periph_pins, .o_volume_format,
		.o_codec_mode, .o_legacy_mode_two_bit, .o_output_level_bit, .i_synth_vol_wr,
		.i_synth_vol_left, .i_synth_vol_right, .o_line_vol_left, .o_line_vol_right,
		.i_cfg_start, .i_cfg_byte_valid, .i_cfg_byte_index, .i_cfg_byte, .i_cfg_end,
		.o_cfg_busy, .o_fw_load, .o_fw_skip);
	cfg_stream_model cfg_stream_model_i (.i_clk, .o_start(i_cfg_start), .o_valid(i_cfg_byte_valid),
		.o_index(i_cfg_byte_index), .o_byte(i_cfg_byte), .o_end(i_cfg_end));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic summarize();
		if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize

	task automatic ctrl_acc(input logic [2:0] off, input logic wr, input logic [7:0] d);
		@(posedge i_clk);
		i_ctrl_wr    <= wr;
		i_ctrl_rd    <= !wr;
		i_ctrl_off   <= off;
		i_ctrl_wdata <= d;
		@(posedge i_clk);
		i_ctrl_wr <= 1'b0;
		i_ctrl_rd <= 1'b0;
		#1 q = o_ctrl_rdata;
	endtask : ctrl_acc

	task automatic codec_acc(input logic ext, input logic [4:0] idx, input logic wr,
		input logic [7:0] d);
		@(posedge i_clk);
		i_codec_wr    <= wr;
		i_codec_rd    <= !wr;
		i_codec_ext   <= ext;
		i_codec_idx   <= idx;
		i_codec_wdata <= d;
		@(posedge i_clk);
		i_codec_wr <= 1'b0;
		i_codec_rd <= 1'b0;
		#1 q = o_codec_rdata;
	endtask : codec_acc

	// Settle two edges so registered pin outputs reflect the inputs
	task automatic settle();
		repeat (2) @(posedge i_clk);
		#1;
	endtask : settle

	task automatic stream(input logic [7:0] glob, input logic [7:0] code, input int gap);
		int w;
		cfg_stream_model_i.send(glob, code, gap);
		for (w = 0; w < 8 && o_cfg_busy !== 1'b0; w++) @(posedge i_clk);
		#1;
		if (w == 8) begin
			error_cnt++;
			summarize();
		end
	endtask : stream

	task automatic synth_wr();
		@(posedge i_clk);
		i_synth_vol_wr    <= 1'b1;
		i_synth_vol_left  <= 8'h11;
		i_synth_vol_right <= 8'h22;
		@(posedge i_clk);
		i_synth_vol_wr <= 1'b0;
		settle();
	endtask : synth_wr

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_ctrl();
		ctrl_acc(3'h3, 1'b1, 8'h08);
		ctrl_acc(3'h4, 1'b1, 8'hc0);
		ctrl_acc(3'h4, 1'b0, 8'h00);
		check("ctrl reg8", q, 8'hc0);
		check("wavetable pins", 8'(o_wavetable_pins), 8'h01);
		check("dsp pins", 8'(o_dsp_on_periph_pins), 8'h01);
		ctrl_acc(3'h4, 1'b1, 8'h00);
		settle();
		check("wavetable pins off", 8'(o_wavetable_pins), 8'h00);
		check("dsp pins off", 8'(o_dsp_on_periph_pins), 8'h00);
		ctrl_acc(3'h3, 1'b1, 8'h01);
		ctrl_acc(3'h4, 1'b1, 8'hff);
		ctrl_acc(3'h4, 1'b0, 8'h00);
		check("ctrl ident", q, 8'h5a);
		ctrl_acc(3'h3, 1'b1, 8'h09);
		ctrl_acc(3'h4, 1'b1, 8'h77);
		ctrl_acc(3'h4, 1'b0, 8'h00);
		check("ctrl beyond reg8", q, 8'h00);
		ctrl_acc(3'h3, 1'b0, 8'h00);
		check("ctrl index", q, 8'h09);
		ctrl_acc(3'h5, 1'b0, 8'h00);
		check("ctrl unmapped", q, 8'h00);
	endtask : t_ctrl

	task automatic t_codec();
		codec_acc(1'b0, 5'h0c, 1'b1, 8'h60);
		settle();
		check("codec mode", 8'(o_codec_mode), 8'h03);
		check("mode two bit", 8'(o_legacy_mode_two_bit), 8'h01);
		codec_acc(1'b0, 5'h10, 1'b1, 8'h30);
		codec_acc(1'b0, 5'h10, 1'b0, 8'h00);
		check("alt feature", q, 8'hb0);
		check("serial format", 8'(o_serial_format), 8'h03);
		codec_acc(1'b0, 5'h19, 1'b1, 8'h00);
		codec_acc(1'b0, 5'h19, 1'b0, 8'h00);
		check("compat reg", q, 8'ha3);
		codec_acc(1'b1, 5'h19, 1'b0, 8'h00);
		check("ext ident", q, 8'h5a);
		for (int k = 0; k < 2; k++) begin
			codec_acc(1'b0, k ? 5'h1d : 5'h1b, 1'b1, 8'hff);
			codec_acc(1'b0, k ? 5'h1d : 5'h1b, 1'b0, 8'h00);
			check("reserved codec", q, 8'h00);
		end
		codec_acc(1'b0, 5'h12, 1'b1, 8'h85);
		codec_acc(1'b0, 5'h12, 1'b0, 8'h00);
		check("muted line no mixer", q, 8'hbf);
	endtask : t_codec

	task automatic t_cfg();
		for (int i = 0; i < 4; i++) begin
			stream(8'(i), i[0] ? 8'h0b : 8'h43, i);
			check("volume format", 8'(o_volume_format), 8'(i));
			check("fw load", 8'(o_fw_load), 8'(i[0]));
			check("fw skip", 8'(o_fw_skip), 8'(!i[0]));
		end
		stream(8'hf8, 8'h43, 0);
		@(posedge i_clk);
		i_periph_rd <= 1'b1;
		settle();
		check("read drive off", 8'(o_isa_read_drive), 8'h00);
		check("global wavetable", 8'(o_wavetable_pins), 8'h01);
		check("global dsp pins", 8'(o_dsp_on_periph_pins), 8'h01);
		codec_acc(1'b0, 5'h12, 1'b0, 8'h00);
		check("muted line mixer", q, 8'h85);
		synth_wr();
		check("line decoupled", o_line_vol_left, 8'h85);
		stream(8'h00, 8'h0b, 1);
		settle();
		check("read drive on", 8'(o_isa_read_drive), 8'h01);
		synth_wr();
		check("synth left", o_line_vol_left, 8'h11);
		check("synth right", o_line_vol_right, 8'h22);
	endtask : t_cfg

	task automatic t_misc();
		for (int k = 0; k < 8; k++) begin
			@(posedge i_clk);
			i_game_sel <= 1'b1;
			i_game_off <= 3'(k);
			settle();
			check("game decode", 8'(o_game_decode), 8'(k <= 5));
		end
		@(posedge i_clk);
		i_serial_enable <= 1'b1;
		settle();
		check("serial run", 8'(o_serial_run), 8'h01);
		check("output level", 8'(o_output_level_bit), 8'h01);
		@(posedge i_clk);
		i_serial_enable <= 1'b0;
		settle();
		check("serial stop", 8'(o_serial_run), 8'h00);
	endtask : t_misc

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		error_cnt = 0;
		n_tests = 0;
		i_rst = 1'b1;
		{i_ctrl_wr, i_ctrl_rd, i_codec_wr, i_codec_rd, i_codec_ext, i_periph_rd, i_game_sel,
			i_serial_enable, i_synth_vol_wr, i_ctrl_off, i_game_off, i_codec_idx, i_ctrl_wdata,
			i_codec_wdata, i_synth_vol_left, i_synth_vol_right} = '0;
		i_remap_en = 1'b1;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_ctrl();
		t_codec();
		t_cfg();
		t_misc();
		summarize();
	end
endmodule : test_config_feature_select

`default_nettype wire
